// ===== shared/node_pkt_consts.svh
// constants for the node packet send/receive register block
// assumes inclusion by bare name from design files; definitions only
`ifndef NODE_PKT_CONSTS_SVH
`define NODE_PKT_CONSTS_SVH

// register byte offsets (low five address bits)
`define OFS_TX_CTRL  5'h00
`define OFS_RX_STAT  5'h04
`define OFS_SEND_PAY 5'h08
`define OFS_SEND_KEY 5'h0C
`define OFS_RX_PAY   5'h10
`define OFS_RX_KEY   5'h14
`define OFS_RSVD     5'h18
`define OFS_TEST     5'h1C

// transmit control fields
`define TXC_OVR      26
`define TXC_OVR_IE   27
`define TXC_FULL     28
`define TXC_FULL_IE  29
`define TXC_INT      31

// receive status fields
`define RXS_FRAME    24
`define RXS_FRAME_IE 25
`define RXS_PAR      26
`define RXS_PAR_IE   27
`define RXS_RCVD     28
`define RXS_RCVD_IE  29
`define RXS_INT      31

// control byte fields
`define CB_PARITY    0
`define CB_DATA      1
`define CB_SEQ_LO    4
`define CB_TYPE_LO   6

// packet type codes
`define TYPE_MC      2'b00
`define TYPE_P2P     2'b01
`define TYPE_NN      2'b10

// reset values
`define RST_WORD     32'h0000_0000
`define RST_BYTE     8'h00

// axi responses
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// ===== shared/node_pkt_pkg.sv
// types shared by the packet block and whoever joins it to the router
// assumes nothing of its surroundings
package node_pkt_pkg;

  // one packet as exchanged with the routing fabric
  // for point-to-point, key[31:16] is source id, key[15:0] destination id
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [31:0] key;
    logic [31:0] payload;
  } pkt_t;

endpackage : node_pkt_pkg

// ===== design/node_packet_tx_rx_regs.sv
// packet send/receive controller with an axi4-lite register slave
// assumes the router shares aclk; packets move on valid/ready handshakes
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "node_pkt_consts.svh"

module node_packet_tx_rx_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output node_pkt_pkg::pkt_t       tx_pkt,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  input  node_pkt_pkg::pkt_t       rx_pkt,
  input  wire logic                rx_frame_err,
  input  wire logic                rx_valid,
  output logic                     rx_ready
);
  import node_pkt_pkg::*;

  // true when the address falls on the given register word
  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    hits = (a[ADDR_W-1:5] == '0) && (a[4:0] == ofs);
  endfunction : hits

  // builds the outgoing packet from software words
  function automatic pkt_t make_pkt(input logic [7:0] cb, input logic [15:0] src,
                                    input logic [31:0] key, input logic [31:0] pay,
                                    input logic has_pay);
    pkt_t p;
    p.ctrl = cb;
    p.key = key;
    p.payload = has_pay ? pay : `RST_WORD;
    p.ctrl[`CB_DATA] = has_pay;
    if (cb[`CB_TYPE_LO+:2] == `TYPE_P2P) begin
      p.ctrl[`CB_SEQ_LO+:2] = key[17:16];
      p.key = {src, key[15:0]};
    end
    p.ctrl[`CB_PARITY] = ~(^{p.ctrl[7:1], p.key, p.payload});
    make_pkt = p;
  endfunction : make_pkt

  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [15:0]       src_id_q;
  logic [7:0]        ctrl_byte_q;
  logic              ovr_q, ovr_ie_q, full_ie_q;
  logic [31:0]       send_pay_q;
  logic              pay_pend_q;
  pkt_t              tx_pkt_q;
  logic              tx_full_q;
  logic [7:0]        rx_ctrl_q;
  logic [31:0]       rx_key_q, rx_pay_q;
  logic              fr_q, par_q, fr_ie_q, par_ie_q, rcvd_ie_q, rx_ready_q;
  logic              test_q;
  logic              wr_go, rd_go, rx_take, tx_take, key_wr, drop;
  logic [31:0]       rd_word;
  wire  [31:0]       m;
  logic              tx_int, rx_int;

  // a write completes once address and data are both held
  // both readies stay low until the answer, so only one write is ever in flight
  assign wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
  assign rd_go   = s_axi_arvalid & arready_q;
  assign rx_take = rx_valid & rx_ready_q;
  assign tx_take = tx_full_q & tx_ready;
  assign key_wr  = wr_go & hits(awaddr_q, `OFS_SEND_KEY);
  assign drop    = key_wr & tx_full_q;
  // interrupt status is derived only, so test mode can never write it
  assign tx_int  = (ovr_q & ovr_ie_q) | (tx_full_q & full_ie_q);
  assign rx_int  = (fr_q & fr_ie_q) | (par_q & par_ie_q)
                 | (~rx_ready_q & rcvd_ie_q);

  // byte-lane write mask from the held strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign m[8*b+:8] = {8{wstrb_q[b]}};
  end

  // write address and data captured in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= `RST_WORD;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q[ADDR_W-1:5] == '0) ? `RESP_OKAY : `RESP_SLVERR;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read word view of every register, write-only bits included
  always_comb begin
    rd_word = `RST_WORD;
    if (hits(s_axi_araddr, `OFS_TX_CTRL)) begin
      rd_word[15:0]         = src_id_q;
      rd_word[23:16]        = ctrl_byte_q;
      rd_word[`TXC_OVR]     = ovr_q;
      rd_word[`TXC_OVR_IE]  = ovr_ie_q;
      rd_word[`TXC_FULL]    = tx_full_q;
      rd_word[`TXC_FULL_IE] = full_ie_q;
      rd_word[`TXC_INT]     = tx_int;
    end else if (hits(s_axi_araddr, `OFS_RX_STAT)) begin
      rd_word[23:16]         = rx_ctrl_q;
      rd_word[`RXS_FRAME]    = fr_q;
      rd_word[`RXS_FRAME_IE] = fr_ie_q;
      rd_word[`RXS_PAR]      = par_q;
      rd_word[`RXS_PAR_IE]   = par_ie_q;
      rd_word[`RXS_RCVD]     = ~rx_ready_q;
      rd_word[`RXS_RCVD_IE]  = rcvd_ie_q;
      rd_word[`RXS_INT]      = rx_int;
    end else if (hits(s_axi_araddr, `OFS_SEND_PAY)) begin
      rd_word = send_pay_q;
    end else if (hits(s_axi_araddr, `OFS_SEND_KEY)) begin
      rd_word = tx_pkt_q.key;
    end else if (hits(s_axi_araddr, `OFS_RX_PAY)) begin
      rd_word = rx_pay_q;
    end else if (hits(s_axi_araddr, `OFS_RX_KEY)) begin
      rd_word = rx_key_q;
    end else if (hits(s_axi_araddr, `OFS_TEST)) begin
      rd_word = {31'h0000_0000, test_q};
    end
  end

  // read channel: data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= `RST_WORD;
      rresp_q   <= `RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= (s_axi_araddr[ADDR_W-1:5] == '0) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // test mode bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_q <= 1'b0;
    end else if (wr_go && hits(awaddr_q, `OFS_TEST) && wstrb_q[0]) begin
      test_q <= wdata_q[0];
    end
  end

  // transmit control fields; overrun set beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_id_q    <= 16'h0000;
      ctrl_byte_q <= `RST_BYTE;
      ovr_q       <= 1'b0;
      ovr_ie_q    <= 1'b0;
      full_ie_q   <= 1'b0;
    end else begin
      if (wr_go && hits(awaddr_q, `OFS_TX_CTRL)) begin
        src_id_q    <= (src_id_q & ~m[15:0]) | (wdata_q[15:0] & m[15:0]);
        ctrl_byte_q <= (ctrl_byte_q & ~m[23:16]) | (wdata_q[23:16] & m[23:16]);
        if (wstrb_q[3]) begin
          ovr_ie_q  <= wdata_q[`TXC_OVR_IE];
          full_ie_q <= wdata_q[`TXC_FULL_IE];
          ovr_q     <= test_q ? wdata_q[`TXC_OVR] : (ovr_q & wdata_q[`TXC_OVR]);
        end
      end
      if (drop) begin
        ovr_q <= 1'b1;
      end
    end
  end

  // payload word and the flag saying it was written since the last send-key write, dropped ones included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_pay_q <= `RST_WORD;
      pay_pend_q <= 1'b0;
    end else if (wr_go && hits(awaddr_q, `OFS_SEND_PAY)) begin
      send_pay_q <= (send_pay_q & ~m) | (wdata_q & m);
      pay_pend_q <= 1'b1;
    end else if (key_wr) begin
      pay_pend_q <= 1'b0;
    end
  end

  // one-entry transmit buffer toward the router
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pkt_q  <= '0;
      tx_full_q <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_full_q <= 1'b0;
      end
      if (key_wr && !tx_full_q) begin
        // types 00, 01 and 10 differ only in how the key word is used
        tx_pkt_q  <= make_pkt(ctrl_byte_q, src_id_q, wdata_q & m, send_pay_q,
                              pay_pend_q);
        tx_full_q <= 1'b1;
      end else if (test_q && wr_go && hits(awaddr_q, `OFS_TX_CTRL) && wstrb_q[3]) begin
        tx_full_q <= wdata_q[`TXC_FULL];
      end
    end
  end

  // receive side: one packet held until the received key is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ctrl_q  <= `RST_BYTE;
      rx_key_q   <= `RST_WORD;
      rx_pay_q   <= `RST_WORD;
      fr_q       <= 1'b0;
      par_q      <= 1'b0;
      fr_ie_q    <= 1'b0;
      par_ie_q   <= 1'b0;
      rcvd_ie_q  <= 1'b0;
      rx_ready_q <= 1'b1;
    end else begin
      if (wr_go && hits(awaddr_q, `OFS_RX_STAT)) begin
        if (wstrb_q[3]) begin
          fr_ie_q   <= wdata_q[`RXS_FRAME_IE];
          par_ie_q  <= wdata_q[`RXS_PAR_IE];
          rcvd_ie_q <= wdata_q[`RXS_RCVD_IE];
          fr_q      <= test_q ? wdata_q[`RXS_FRAME] : (fr_q & wdata_q[`RXS_FRAME]);
          par_q     <= test_q ? wdata_q[`RXS_PAR] : (par_q & wdata_q[`RXS_PAR]);
          if (test_q) begin
            rx_ready_q <= ~wdata_q[`RXS_RCVD];
          end
        end
        if (test_q) begin
          rx_ctrl_q <= (rx_ctrl_q & ~m[23:16]) | (wdata_q[23:16] & m[23:16]);
        end
      end
      if (test_q && wr_go && hits(awaddr_q, `OFS_RX_PAY)) begin
        rx_pay_q <= (rx_pay_q & ~m) | (wdata_q & m);
      end
      if (test_q && wr_go && hits(awaddr_q, `OFS_RX_KEY)) begin
        rx_key_q <= (rx_key_q & ~m) | (wdata_q & m);
      end
      if (rd_go && hits(s_axi_araddr, `OFS_RX_KEY)) begin
        rx_ready_q <= 1'b1;
      end
      // flags set here win over a software clear in the same cycle
      if (rx_take) begin
        rx_ready_q <= 1'b0;
        rx_ctrl_q  <= rx_pkt.ctrl;
        if (rx_pkt.ctrl[`CB_DATA]) begin
          rx_pay_q <= rx_pkt.payload;
        end
        if (rx_pkt.ctrl[`CB_TYPE_LO+:2] == `TYPE_P2P) begin
          rx_key_q <= {14'h0000, rx_pkt.ctrl[`CB_SEQ_LO+:2], rx_pkt.key[31:16]};
        end else begin
          rx_key_q <= rx_pkt.key;
        end
        if (rx_frame_err) begin
          fr_q <= 1'b1;
        end
        if (~^{rx_pkt.ctrl, rx_pkt.key, rx_pkt.ctrl[`CB_DATA] ? rx_pkt.payload : `RST_WORD}) begin
          par_q <= 1'b1;
        end
      end
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign tx_pkt        = tx_pkt_q;
  assign tx_valid      = tx_full_q;
  assign rx_ready      = rx_ready_q;

endmodule : node_packet_tx_rx_regs

// ===== test/router_model.sv
// router stand-in: takes sent packets, offers received ones on request
// assumes the block's aclk; stall holds off taking sent packets
module router_model (
  input  wire logic          aclk,
  input  wire logic          stall,
  input  node_pkt_pkg::pkt_t tx_pkt,
  input  wire logic          tx_valid,
  output logic               tx_ready,
  output node_pkt_pkg::pkt_t rx_pkt = '0,
  output logic               rx_valid = 1'b0,
  output logic               rx_frame_err = 1'b0,
  input  wire logic          rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import node_pkt_pkg::*;
  pkt_t last = '0;
  int   n_got = 0;
  // takes as sent, no time stamp added on the way
  assign tx_ready = !stall;
  // count sent packets; once a packet is taken its lines stop holding it
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      last  <= tx_pkt;
      n_got <= n_got + 1;
    end
    if (rx_valid && rx_ready) begin
      rx_valid     <= 1'b0;
      rx_pkt       <= ~rx_pkt;
      rx_frame_err <= ~rx_frame_err;
    end
  end
  // offer one packet from the next edge until the block takes it
  task automatic offer(input pkt_t p, input logic fe);
    @(posedge aclk);
    rx_pkt       <= p;
    rx_valid     <= 1'b1;
    rx_frame_err <= fe;
  endtask : offer
endmodule : router_model

// ===== test/node_pkt_monitor.sv
// checker on the block ports: read answers, launch and receive
// assumes a bind onto node_packet_tx_rx_regs; one clock domain
module node_pkt_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input node_pkt_pkg::pkt_t     tx_pkt,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic              rx_ready
);
  import node_pkt_pkg::*;
  // read taken, and read of the received key word
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_key  = ar_take && s_axi_araddr[4:0] == 5'h14 && s_axi_araddr[ADDR_W-1:5] == '0;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_aw_take;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("write address taken twice");
  property p_wr_resp;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid
      |=> s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_lat;
    ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_free;
    $fell(s_axi_rvalid) |-> s_axi_arready;
  endproperty
  a_rd_free: assert property (p_rd_free) else $error("read channel not freed");
  property p_rd_err;
    ar_take && s_axi_araddr[ADDR_W-1:5] != '0 |=> s_axi_rresp == 2'b10 && s_axi_rdata == '0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_pkt);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("offered packet changed");
  property p_tx_launch;
    $rose(tx_valid) |-> $rose(s_axi_bvalid);
  endproperty
  a_tx_launch: assert property (p_tx_launch) else $error("launch without write");
  property p_tx_par;
    tx_valid |-> ^tx_pkt && (tx_pkt.ctrl[1] || tx_pkt.payload == '0);
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("sent packet bad");
  property p_rx_take;
    rx_valid && rx_ready |=> !rx_ready;
  endproperty
  a_rx_take: assert property (p_rx_take) else $error("receive not held");
  property p_rx_rise;
    $rose(rx_ready) |-> $past(rd_key) || $rose(s_axi_bvalid);
  endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("receive freed early");
  c_tx_take: cover property (tx_valid && tx_ready);
  c_rx_take: cover property (rx_valid && rx_ready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : node_pkt_monitor

bind node_packet_tx_rx_regs node_pkt_monitor #(.ADDR_W(ADDR_W)) mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .tx_pkt, .tx_valid, .tx_ready,
  .rx_valid, .rx_ready
);

// ===== test/tb.sv
// bench: axi4-lite register traffic, router stand-in on the packet side
// assumes package, router model and monitor compile first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import node_pkt_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_valid, tx_ready;
  logic        rx_valid, rx_ready, rx_frame_err;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  pkt_t        tx_pkt, rx_pkt, p, q;
  logic [1:0]  ty [3] = '{2'b01, 2'b10, 2'b00};
  logic [31:0] ky [3] = '{32'h0003_BEEF, 32'h8000_0001, 32'hCAFE_F00D};
  int          miscompares = 0, checks_done = 0;
  node_packet_tx_rx_regs uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_pkt, .tx_valid, .tx_ready, .rx_pkt,
    .rx_frame_err, .rx_valid, .rx_ready
  );
  router_model rtr (
    .aclk, .stall, .tx_pkt, .tx_valid, .tx_ready, .rx_pkt, .rx_valid, .rx_frame_err, .rx_ready
  );
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one edge, with a bound on any wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      miscompares++;
      print_verdict();
    end
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(72'(s_axi_bresp), 72'(er));
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(72'({s_axi_rresp, s_axi_rdata}), 72'({er, e}));
  endtask : rc
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (rtr.n_got != k) tick(n);
  endtask : wait_got
  // packet with odd parity over all its bits
  function automatic pkt_t mk(input logic [7:0] c, input logic [31:0] k, input logic [31:0] d);
    mk = '{c, k, d};
    mk.ctrl[0] = ~^{c[7:1], k, d};
  endfunction : mk
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h000, 32'h0000_0000);
    rc(12'h004, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, {8'h00, ty[i], 6'h07, 16'h1234});
      if (i < 2) wr(12'h008, 32'hA5A5_0000 + 32'(i));
      wr(12'h00C, ky[i]);
      wait_got(i + 1);
      p = mk({ty[i], i == 0 ? 2'b11 : 2'b00, 2'b01, i < 2, 1'b0},
             i == 0 ? {16'h1234, ky[i][15:0]} : ky[i], i < 2 ? 32'hA5A5_0000 + 32'(i) : '0);
      chk(rtr.last, p);
    end
    // router stalls, so the second launch meets a full buffer
    stall <= 1'b1;
    wr(12'h00C, 32'h0000_0001);
    wr(12'h00C, 32'h0000_0002);
    rc(12'h000, 32'h1407_1234);
    wr(12'h000, 32'h0C07_1234);
    rc(12'h000, 32'h9C07_1234);
    wr(12'h000, 32'h2007_1234);
    rc(12'h000, 32'hB007_1234);
    stall <= 1'b0;
    wait_got(4);
    repeat (4) @(posedge aclk);
    chk(72'(rtr.n_got), 72'd4);
    chk(72'(rtr.last.key), 72'h1);
    rc(12'h000, 32'h2007_1234);
    // second received packet waits until the key word is read
    wr(12'h004, 32'h2000_0000);
    p = mk(8'h62, 32'h00AB_0055, 32'h1357_9BDF);
    q = mk(8'h00, 32'h1234_5678, 32'h0);
    q.ctrl[0] = ~q.ctrl[0];
    rtr.offer(p, 1'b0);
    rc(12'h004, {8'hB0, p.ctrl, 16'h0000});
    rtr.offer(q, 1'b1);
    rc(12'h010, p.payload);
    rc(12'h014, 32'h0002_00AB);
    rc(12'h004, {8'hB5, q.ctrl, 16'h0000});
    rc(12'h014, 32'h1234_5678);
    wr(12'h004, 32'h0A00_0000);
    rc(12'h004, {8'h0A, q.ctrl, 16'h0000});
    // test mode opens read-only fields
    wr(12'h01C, 32'h0000_0001);
    wr(12'h004, 32'h005A_0000);
    rc(12'h004, 32'h005A_0000);
    wr(12'h01C, 32'h0000_0000);
    wr(12'h004, 32'h0000_0000);
    rc(12'h004, 32'h005A_0000);
    // reserved slot ignores writes; past the map the bus refuses
    wr(12'h018, 32'hFFFF_FFFF);
    rc(12'h018, 32'h0000_0000);
    wr(12'h020, 32'h0000_0001, 2'b10);
    rc(12'h020, 32'h0000_0000, 2'b10);
    print_verdict();
  end
endmodule : tb
